//--- design/pad_float_consts.svh
`ifndef PAD_FLOAT_CONSTS_SVH
`define PAD_FLOAT_CONSTS_SVH

// Register byte offsets on the APB bus.
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004

// Control register field positions.
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_SR_ASYNC_BIT 2
`define CTRL_SR_SETS_BIT 3

// Status register field positions.
`define STATUS_PAD_FLOAT_BIT 0
`define STATUS_FLOAT_A_BIT 1
`define STATUS_FLOAT_B_BIT 2
`define STATUS_LAST_B_BIT 3
`define STATUS_GLOBAL_BIT 4

// Reset values.
`define CTRL_RESET 4'h0
`define FLOAT_RESET 1'h0

`endif

//--- design/pad_float_pkg.sv
package pad_float_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_DDR = 2'h1,
    MODE_LATCH = 2'h2
  } mode_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
  } edge_state_t;

  typedef struct packed {
    mode_t mode;
    logic srAsync;
    logic srSets;
    logic floatA;
    logic floatB;
    logic lastB;
    logic [31:0] prdata;
    logic slvErr;
  } float_state_t;

endpackage

//--- design/edge_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "pad_float_consts.svh"

// Brings the drive clocks into the core_clk domain and flags their rising edges.
module edge_sync #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [1:0] asyncIn,
  output logic [1:0] rise
);
  import pad_float_pkg::*;

  edge_state_t state_r;
  edge_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (clkEn) begin
      state_nxt.sync1 = asyncIn;
      state_nxt.sync2 = state_r.sync1;
      state_nxt.prev = state_r.sync2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Only the second stage and its delayed copy feed the edge detector.
  assign rise = state_r.sync2 & ~state_r.prev & {WIDTH{clkEn}};

endmodule
`default_nettype wire

//--- design/pad_output_enable_register.sv
// Behaviour
// (RL1) Float register captures its request on a clock edge only while enable is high.
// (RL2) Captured high floats the pad; captured low drives valid data.
// (RL3) Synchronous set/reset high at an edge clears the float register; a set-type configuration (srSets) loads one instead.
// (RL4) Asynchronous set/reset changes the pad at once; set floats, reset drives.
// (RL5) Global float forces high impedance whatever the float register holds.
// (RL6) Latch mode: pad follows the float request while the latch is open.
// (RL7) DDR: register A on drive clock A edges, B on B; pad follows latest.
// (RL8) Driving logic changes the shared enable only between an A and next B edge.
// (RL9) DDR synchronous reset on an A edge clears register A.
// (RL10) With enable low each float register holds its value.
`timescale 1ns/100ps
`default_nettype none
`include "pad_float_consts.svh"

module pad_output_enable_register (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic floatRegEnable,
  input wire logic presetClearIn,
  input wire logic floatRequestFirstHalf,
  input wire logic floatRequestSecondHalf,
  input wire logic driveClockA,
  input wire logic driveClockB,
  input wire logic globalFloat,
  output logic padOeN
);
  import pad_float_pkg::*;

  float_state_t state_r;
  float_state_t state_nxt;
  logic [1:0] driveRise;
  logic srValue;
  logic asyncHit;
  logic latchOpen;
  logic padFloat;

  edge_sync #(
    .WIDTH(2)
  ) u_edge_sync (
    .core_clk(core_clk),
    .srst(srst),
    .clkEn(clkEn),
    .asyncIn({driveClockB, driveClockA}),
    .rise(driveRise)
  );

  function automatic logic addrIs(input logic [11:0] a, input logic [11:0] off);
    addrIs = (a[11:2] == off[11:2]);
  endfunction

  // A set-type configuration loads one, a reset-type loads zero.
  assign srValue = state_r.srSets;
  assign asyncHit = state_r.srAsync && presetClearIn;
  assign latchOpen = (state_r.mode == MODE_LATCH) && floatRegEnable && clkEn;

  always_comb begin
    state_nxt = state_r;
    if (clkEn) begin
      if (state_r.mode == MODE_DDR) begin
        if (driveRise[0]) begin
          if (!state_r.srAsync && presetClearIn) begin
            state_nxt.floatA = srValue; // RL9
          end else if (floatRegEnable) begin
            state_nxt.floatA = floatRequestFirstHalf; // RL7
          end
          state_nxt.lastB = 1'b0; // RL7
        end
        if (driveRise[1]) begin
          if (!state_r.srAsync && presetClearIn) begin
            state_nxt.floatB = srValue;
          end else if (floatRegEnable) begin
            state_nxt.floatB = floatRequestSecondHalf; // RL7
          end
          state_nxt.lastB = 1'b1; // RL7
        end
      end else if (!state_r.srAsync && presetClearIn) begin
        state_nxt.floatA = srValue; // RL3
      end else if (floatRegEnable) begin
        state_nxt.floatA = floatRequestFirstHalf; // RL1 RL6
      end
      if (asyncHit) begin
        state_nxt.floatA = srValue; // RL4
        state_nxt.floatB = srValue; // RL4
      end
      state_nxt.slvErr = 1'b0;
      if (psel && !penable) begin
        state_nxt.prdata = 32'h0;
        if (addrIs(paddr, `CTRL_OFFSET)) begin
          if (pwrite) begin
            state_nxt.mode = mode_t'(pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
            state_nxt.srAsync = pwdata[`CTRL_SR_ASYNC_BIT];
            state_nxt.srSets = pwdata[`CTRL_SR_SETS_BIT];
            if (pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == 2'h3) begin
              state_nxt.mode = state_r.mode;
              state_nxt.slvErr = 1'b1;
            end
          end else begin
            state_nxt.prdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = state_r.mode;
            state_nxt.prdata[`CTRL_SR_ASYNC_BIT] = state_r.srAsync;
            state_nxt.prdata[`CTRL_SR_SETS_BIT] = state_r.srSets;
          end
        end else if (addrIs(paddr, `STATUS_OFFSET)) begin
          if (pwrite) begin
            state_nxt.slvErr = 1'b1;
          end else begin
            state_nxt.prdata[`STATUS_PAD_FLOAT_BIT] = padFloat;
            state_nxt.prdata[`STATUS_FLOAT_A_BIT] = state_r.floatA;
            state_nxt.prdata[`STATUS_FLOAT_B_BIT] = state_r.floatB;
            state_nxt.prdata[`STATUS_LAST_B_BIT] = state_r.lastB;
            state_nxt.prdata[`STATUS_GLOBAL_BIT] = globalFloat;
          end
        end else begin
          state_nxt.slvErr = 1'b1;
        end
      end else if (psel && penable) begin
        state_nxt.slvErr = state_r.slvErr;
      end
    end
    // RL10: with clkEn low, state_nxt keeps every field of state_r.
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= '0;
      state_r.mode <= mode_t'(2'(`CTRL_RESET >> `CTRL_MODE_LSB));
      state_r.floatA <= `FLOAT_RESET;
      state_r.floatB <= `FLOAT_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_comb begin
    if (globalFloat) begin
      padFloat = 1'b1; // RL5
    end else if (asyncHit) begin
      padFloat = srValue; // RL4
    end else if (latchOpen) begin
      padFloat = floatRequestFirstHalf; // RL6
    end else if (state_r.mode == MODE_DDR) begin
      padFloat = state_r.lastB ? state_r.floatB : state_r.floatA; // RL7
    end else begin
      padFloat = state_r.floatA; // RL2
    end
  end

  // The pad enable is low while the pad drives data.
  assign padOeN = padFloat; // RL2
  assign pready = clkEn;
  assign prdata = state_r.prdata;
  assign pslverr = state_r.slvErr && psel && penable;

endmodule
`default_nettype wire

//--- tb/pad_oe_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pad_oe_sva (
  input wire logic core_clk, srst, clkEn, psel, penable, pwrite, globalFloat, padOeN,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic floatRegEnable, presetClearIn, floatRequestFirstHalf, floatRequestSecondHalf
);
  logic [3:0] ctl_r;
  wire logic g = globalFloat;
  wire logic r = floatRequestFirstHalf;
  wire logic q = clkEn && !psel && !presetClearIn && !g;
  wire logic e = q && floatRegEnable;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Shadow of the control word, so each check knows the active mode.
  always_ff @(posedge core_clk)
    if (srst) ctl_r <= 4'h0;
    else if (clkEn && psel && !penable && pwrite && paddr == 12'h000 && pwdata[1:0] != 2'h3)
      ctl_r <= pwdata[3:0];
  sequence s_same;
    ctl_r == 4'h1 && e && floatRequestSecondHalf == r && $stable(r);
  endsequence
  sequence s_clr;
    ctl_r == 4'h1 && clkEn && !psel && presetClearIn;
  endsequence
  property p_hold; ctl_r == 4'h0 && q && !floatRegEnable |=> g || $stable(padOeN); endproperty
  property p_cap; ctl_r == 4'h0 && e |=> g || padOeN == $past(r); endproperty
  property p_srs; ctl_r == 4'h0 && clkEn && !psel && presetClearIn |=> g || !padOeN; endproperty
  property p_sra; ctl_r[2] && presetClearIn && !g |-> padOeN == ctl_r[3]; endproperty
  property p_glb; g |-> padOeN; endproperty
  property p_lat; ctl_r == 4'h2 && e |-> padOeN == r; endproperty
  property p_ddr; s_same [*8] |=> g || padOeN == r; endproperty
  property p_clr; s_clr [*8] |=> g || !padOeN; endproperty
  a_hold: assert property (p_hold) else $error("pad moved while held");
  a_cap: assert property (p_cap) else $error("capture wrong");
  a_srs: assert property (p_srs) else $error("sync clear missed");
  a_sra: assert property (p_sra) else $error("async set or clear missed");
  a_glb: assert property (p_glb) else $error("global float ignored");
  a_lat: assert property (p_lat) else $error("latch not transparent");
  a_ddr: assert property (p_ddr) else $error("ddr pair not loaded");
  a_clr: assert property (p_clr) else $error("ddr clear missed");
endmodule
bind pad_output_enable_register pad_oe_sva chk_u (.*);
`default_nettype wire

//--- tb/fabric_model.sv
`timescale 1ns/100ps
`default_nettype none
module fabric_model (
  input wire logic enReq,
  output logic driveClockA,
  output logic driveClockB,
  output logic floatRegEnable
);
  initial driveClockA = 1'b0;
  initial floatRegEnable = 1'b0;
  always #95 driveClockA = !driveClockA;
  assign driveClockB = !driveClockA;
  // The shared enable moves only just after a first-clock rise.
  always @(posedge driveClockA) floatRegEnable <= enReq;
endmodule
`default_nettype wire

//--- tb/pad_output_enable_register_test.sv
`timescale 1ns/100ps
`default_nettype none
module pad_output_enable_register_test;
  logic core_clk, srst, clkEn, psel, penable, pwrite, pready, pslverr, err, enReq;
  logic floatRegEnable, presetClearIn, floatRequestFirstHalf, floatRequestSecondHalf;
  logic driveClockA, driveClockB, globalFloat, padOeN;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int miscompares, checked, seed, k, expPad;
  fabric_model fab_u (.*);
  pad_output_enable_register dut_u (.*);
  task cmp(input string n, input logic [31:0] e, input logic [31:0] v);
    checked++;
    if (v !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, v);
    end
  endtask
  task final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      final_report;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task pad(input logic e);
    @(negedge core_clk);
    cmp("padOeN", {31'h0, e}, {31'h0, padOeN});
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end
  initial begin
    seed = 22;
    srst = 1'b1;
    {clkEn, psel, penable, pwrite, paddr, pwdata, enReq} = '0;
    {presetClearIn, floatRequestFirstHalf, floatRequestSecondHalf, globalFloat} = '0;
    tick(8);
    srst <= 1'b0;
    clkEn <= 1'b1;
    apb(1'b0, 12'h000, 0);
    cmp("ctrl", 0, rd);
    apb(1'b1, 12'h004, 1);
    cmp("status write err", 1, {31'h0, err});
    apb(1'b0, 12'h008, 0);
    cmp("unmapped err", 1, {31'h0, err});
    apb(1'b1, 12'h000, 3);
    cmp("mode err", 1, {31'h0, err});
    expPad = 0;
    repeat (12) begin
      k = $random(seed);
      enReq <= k[0];
      tick(10);
      floatRequestFirstHalf <= k[1];
      if (k[0]) expPad = k[1];
      tick(3);
      pad(expPad[0]);
    end
    floatRequestFirstHalf <= 1'b1;
    enReq <= 1'b1;
    tick(12);
    enReq <= 1'b0;
    tick(10);
    presetClearIn <= 1'b1;
    tick(1);
    presetClearIn <= 1'b0;
    pad(1'b0);
    apb(1'b1, 12'h000, 32'h0000000c);
    @(posedge core_clk);
    presetClearIn <= 1'b1;
    #3 cmp("async set", 1, {31'h0, padOeN});
    @(posedge core_clk);
    presetClearIn <= 1'b0;
    apb(1'b1, 12'h000, 32'h00000004);
    @(posedge core_clk);
    presetClearIn <= 1'b1;
    #3 cmp("async clear", 0, {31'h0, padOeN});
    @(posedge core_clk);
    presetClearIn <= 1'b0;
    globalFloat <= 1'b1;
    #3 cmp("global", 1, {31'h0, padOeN});
    @(posedge core_clk);
    globalFloat <= 1'b0;
    apb(1'b1, 12'h000, 32'h00000002);
    enReq <= 1'b1;
    tick(10);
    for (int v = 0; v < 3; v++) begin
      @(posedge core_clk);
      floatRequestFirstHalf <= v[0];
      #3 cmp("latch", {31'h0, v[0]}, {31'h0, padOeN});
    end
    apb(1'b0, 12'h000, 0);
    cmp("ctrl readback", 32'h00000002, rd);
    @(posedge core_clk);
    globalFloat <= 1'b1;
    apb(1'b0, 12'h004, 0);
    cmp("status", 32'h00000011, rd);
    globalFloat <= 1'b0;
    apb(1'b1, 12'h000, 32'h00000001);
    floatRequestFirstHalf <= 1'b1;
    floatRequestSecondHalf <= 1'b1;
    tick(24);
    pad(1'b1);
    presetClearIn <= 1'b1;
    tick(20);
    pad(1'b0);
    @(posedge core_clk);
    presetClearIn <= 1'b0;
    floatRequestFirstHalf <= 1'b0;
    k = 0;
    repeat (24) begin
      @(negedge core_clk);
      k += padOeN;
    end
    cmp("ddr halves", 1, {31'h0, k > 4 && k < 20});
    final_report;
  end
endmodule
`default_nettype wire
